// *** hdl/byte_store.sv ***
module byte_store
  import page_map_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [6:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_idx,
  output logic [7:0] rd_data
);
  // ****************************************************************
  // Flip-flop byte array
  // ****************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } store_s;

  store_s st_r;
  store_s st_nxt;

  // Write one entry per cycle
  always_comb
  begin
    st_nxt = st_r;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (wr_en && (int'(wr_idx) == i))
      begin
        st_nxt.mem[i] = wr_data;
      end
    end
  end

  // Register the copy
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Out of range reads as zero
  assign rd_data = (int'(rd_idx) < DEPTH) ? st_r.mem[rd_idx] : ZERO_BYTE;
endmodule

// *** hdl/register_page_selector.sv ***
// How it works
// - Host writes selector to change page
// - Selector decoded at 0x7F, every page
// - Codes 00..03 pick ctrl, rx, tx, test
// - Rx page holds last received block bits
// - Tx page host writable, readable back
// - Test page locked until unlock code
// - Ctrl 0x00 and 0x34..0x7E reserved
// - Status flags raise interrupt when enabled
module register_page_selector
  import page_map_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH,
  parameter int NFLAG = DATA_W
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic rx_cu_valid,
  input wire logic [6:0] rx_cu_idx,
  input wire logic [7:0] rx_cu_data,
  input wire logic [6:0] tx_cu_idx,
  output logic [7:0] tx_cu_data,
  input wire logic [NFLAG-1:0] flag_events,
  output logic int_b_oe,
  output logic test_mode,
  output logic [7:0] page_sel
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] page;        // Active page selector
    logic unlocked;          // Test page key accepted
    logic [NFLAG-1:0] stat;  // Sticky flag status
    logic [NFLAG-1:0] ena;   // Interrupt enables
    logic [7:0] rdata;       // Read data holding
  } sel_s;

  sel_s st_r;
  sel_s st_nxt;

  logic sel_hit;        // Selector address
  logic on_ctrl;
  logic on_rx;
  logic on_tx;
  logic on_test;
  logic ctrl_rsvd;      // Reserved control word
  logic [7:0] rx_rd;
  logic [7:0] tx_rd;
  logic tx_wr;
  logic tx_host_rd;     // Host read owns the tx read port

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign sel_hit = (addr == PAGE_SEL_ADDR);
  assign on_ctrl = (st_r.page == PAGE_CTRL);
  assign on_rx = (st_r.page == PAGE_RX);
  assign on_tx = (st_r.page == PAGE_TX);
  assign on_test = (st_r.page == PAGE_TEST);
  assign ctrl_rsvd = (addr == CTRL_RSVD_LO) ||
                     ((addr >= CTRL_RSVD_FROM) && (addr <= CTRL_RSVD_TO));
  // Host buffer writes only land on the tx page
  assign tx_wr = wr_en && on_tx && !sel_hit;
  // One read port only: the host wins for that cycle, fetch sees the host's entry
  assign tx_host_rd = rd_en && on_tx && !sel_hit;

  // Receiver capture buffer, filled by the block receiver
  byte_store #(.DEPTH(DEPTH)) u_rx_buf
  (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(rx_cu_valid),
    .wr_idx(rx_cu_idx),
    .wr_data(rx_cu_data),
    .rd_idx(addr),
    .rd_data(rx_rd)
  );

  // Transmitter buffer; its one read port is shared by host reads and the audio_transmitter feed
  byte_store #(.DEPTH(DEPTH)) u_tx_buf
  (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(tx_wr),
    .wr_idx(addr),
    .wr_data(wr_data),
    .rd_idx(tx_host_rd ? addr : tx_cu_idx),
    .rd_data(tx_rd)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    // Set wins over a clear in the same cycle
    if (wr_en && on_ctrl && (addr == CTRL_STATUS_ADDR))
    begin
      st_nxt.stat = st_r.stat & ~wr_data[NFLAG-1:0];
    end
    st_nxt.stat = st_nxt.stat | flag_events;
    if (wr_en && sel_hit)
    begin
      st_nxt.page = wr_data;
    end
    else if (wr_en && on_ctrl && (addr == CTRL_ENABLE_ADDR))
    begin
      st_nxt.ena = wr_data[NFLAG-1:0];
    end
    else if (wr_en && on_test && (addr == TEST_KEY_ADDR))
    begin
      // Wrong key relocks the page
      st_nxt.unlocked = (wr_data == TEST_UNLOCK_CODE);
    end
    // Read mux; reserved and unknown locations give zero
    if (rd_en)
    begin
      if (sel_hit)
      begin
        st_nxt.rdata = st_r.page;
      end
      else if (on_ctrl && ctrl_rsvd)
      begin
        st_nxt.rdata = ZERO_BYTE;
      end
      else if (on_ctrl && (addr == CTRL_STATUS_ADDR))
      begin
        st_nxt.rdata = st_r.stat;
      end
      else if (on_ctrl && (addr == CTRL_ENABLE_ADDR))
      begin
        st_nxt.rdata = st_r.ena;
      end
      else if (on_rx)
      begin
        st_nxt.rdata = rx_rd;
      end
      else if (on_tx)
      begin
        st_nxt.rdata = tx_rd;
      end
      else
      begin
        st_nxt.rdata = ZERO_BYTE;
      end
    end
  end

  // Register the copy
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '{page: PAGE_SEL_RST, unlocked: 1'b0, stat: '0, ena: '0,
                rdata: ZERO_BYTE};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_data = st_r.rdata;
  assign page_sel = st_r.page;
  assign tx_cu_data = tx_rd;
  // Open-drain pull low while any enabled flag stands
  assign int_b_oe = |(st_r.stat & st_r.ena);
  // Test mode stands while the test page is selected and the key is accepted
  assign test_mode = on_test && st_r.unlocked;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_sel_write: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && sel_hit |=> page_sel == $past(wr_data))
    else $error("selector write not taken");
  chk_sel_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_en && sel_hit |=> rd_data == $past(page_sel))
    else $error("selector not readable");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_b)
    rd_en && on_ctrl && ctrl_rsvd && !sel_hit |=> rd_data == 8'h00)
    else $error("reserved word not zero");
  chk_test_lock: assert property (@(posedge clk) disable iff (!rst_b)
    test_mode |-> page_sel == PAGE_TEST)
    else $error("test mode off test page");
  chk_lock_key: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && on_test && addr == TEST_KEY_ADDR && wr_data != TEST_UNLOCK_CODE
    |=> !test_mode)
    else $error("wrong key unlocked");
  chk_irq_set: assert property (@(posedge clk) disable iff (!rst_b)
    |(flag_events & st_r.ena) && !(wr_en && on_ctrl && addr == CTRL_ENABLE_ADDR)
    |=> int_b_oe)
    else $error("interrupt not raised");
  chk_tx_back: assert property (@(posedge clk) disable iff (!rst_b)
    tx_wr && (int'(addr) < DEPTH) ##1 !wr_en ##1
    (rd_en && on_tx && addr == $past(addr, 2)) |=> rd_data == $past(wr_data, 3))
    else $error("tx readback mismatch");
  chk_rx_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_en && on_rx && !sel_hit |=> rd_data == $past(rx_rd))
    else $error("rx buffer read wrong");
  chk_page_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(wr_en && sel_hit) |=> $stable(page_sel))
    else $error("page changed without write");
  cov_page_rx: cover property (@(posedge clk) disable iff (!rst_b)
    wr_en && sel_hit && wr_data == PAGE_RX);
  cov_page_tx: cover property (@(posedge clk) disable iff (!rst_b) tx_wr);
  cov_unlock: cover property (@(posedge clk) disable iff (!rst_b) test_mode);
  cov_irq: cover property (@(posedge clk) disable iff (!rst_b) int_b_oe);
endmodule

// *** shared/page_map_pkg.sv ***
package page_map_pkg;
  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int ADDR_W = 7;              // Register address width
  localparam int DATA_W = 8;              // Register data width
  localparam logic [6:0] PAGE_SEL_ADDR = 7'h7F;   // Selector, every page
  localparam logic [6:0] CTRL_RSVD_LO = 7'h00;    // Lone reserved word
  localparam logic [6:0] CTRL_RSVD_FROM = 7'h34;  // Reserved range start
  localparam logic [6:0] CTRL_RSVD_TO = 7'h7E;    // Reserved range end
  localparam logic [6:0] CTRL_STATUS_ADDR = 7'h02; // Flag status word
  localparam logic [6:0] CTRL_ENABLE_ADDR = 7'h03; // Flag enable word
  localparam int BUF_DEPTH = 48;          // Bytes per C/U buffer page

  // ****************************************************************
  // Page codes and reset values
  // ****************************************************************
  localparam logic [7:0] PAGE_CTRL = 8'h00;
  localparam logic [7:0] PAGE_RX = 8'h01;
  localparam logic [7:0] PAGE_TX = 8'h02;
  localparam logic [7:0] PAGE_TEST = 8'h03;
  localparam logic [7:0] PAGE_SEL_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Arbitrary unlock code, not a real value
  localparam logic [7:0] TEST_UNLOCK_CODE = 8'hA5;
  localparam logic [6:0] TEST_KEY_ADDR = 7'h7E;  // Key word on test page
endpackage

// *** tb/host_model.sv ***
// Host on the control port: single byte writes and reads
module host_model
  import page_map_pkg::*;
(
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wr_data = '0;
  end
  // Write strobe lasts one cycle; selector writes go here too
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    // Released data must not keep the last value
    wr_data = ~d;
  endtask
  // Read byte is taken one cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    d = rd_data;
  endtask
endmodule

// *** tb/test_register_page_selector.sv ***
module test_register_page_selector
  import page_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_en, rd_en, rx_cu_valid = 1'b0, int_b_oe, test_mode;
  logic [6:0] addr, rx_cu_idx = '0, tx_cu_idx = '0;
  logic [7:0] wr_data, rd_data, rx_cu_data = '0, tx_cu_data, page_sel;
  logic [7:0] flag_events = '0;
  int errors = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  register_page_selector u_dut (.clk(clk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rx_cu_valid(rx_cu_valid),
    .rx_cu_idx(rx_cu_idx), .rx_cu_data(rx_cu_data), .tx_cu_idx(tx_cu_idx),
    .tx_cu_data(tx_cu_data), .flag_events(flag_events), .int_b_oe(int_b_oe),
    .test_mode(test_mode), .page_sel(page_sel));
  host_model u_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data));
  // Buffer pages read zero beyond their depth
  function automatic logic [7:0] buf_expect(logic [6:0] a, logic [7:0] d);
    return (int'(a) < BUF_DEPTH) ? d : ZERO_BYTE;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input string what, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd(a, v);
    chk(what, exp, v);
  endtask
  // One cycle event pulse on the flag inputs
  task automatic pulse(input logic [7:0] m);
    @(negedge clk);
    flag_events = m;
    @(negedge clk);
    flag_events = '0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog: the whole run needs well under 2500 cycles
  initial
  begin
    #20000;
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    logic [6:0] a;
    logic [7:0] d;
    logic [7:0] tx_model [BUF_DEPTH];
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    void'($urandom(32'h661d));
    chk("page_sel", PAGE_SEL_RST, page_sel);
    rchk("sel rst", PAGE_SEL_ADDR, PAGE_SEL_RST);
    $display("test reset done");
    // Codes 03 down to 00, each read back through the selector word on its own page
    for (int p = 3; p >= 0; p--)
    begin
      u_host.wr(PAGE_SEL_ADDR, 8'(p));
      chk("page_sel", 8'(p), page_sel);
      rchk("sel", PAGE_SEL_ADDR, 8'(p));
      chk("test_mode", 8'h00, {7'h0, test_mode});
    end
    $display("test pages done");
    u_host.wr(PAGE_SEL_ADDR, PAGE_TX);
    for (int j = 0; j < BUF_DEPTH; j++)
    begin
      tx_model[j] = ZERO_BYTE;
    end
    for (int i = 0; i < 10; i++)
    begin
      a = (i == 0) ? 7'h00 : (i == 1) ? 7'(BUF_DEPTH - 1) : (i == 2) ? 7'(BUF_DEPTH) :
          7'($urandom % BUF_DEPTH);
      d = 8'($urandom);
      u_host.wr(a, d);
      if (int'(a) < BUF_DEPTH)
      begin
        tx_model[a] = d;
      end
      rchk("tx rd", a, buf_expect(a, d));
      // Fetch at its own index, not the host address
      tx_cu_idx = 7'($urandom % BUF_DEPTH);
      @(negedge clk);
      chk("tx_cu_data", tx_model[tx_cu_idx], tx_cu_data);
    end
    $display("test tx done");
    u_host.wr(PAGE_SEL_ADDR, PAGE_RX);
    for (int i = 0; i < 8; i++)
    begin
      a = (i == 0) ? 7'(BUF_DEPTH - 1) : 7'($urandom % BUF_DEPTH);
      d = 8'($urandom);
      @(negedge clk);
      rx_cu_valid = 1'b1;
      rx_cu_idx = a;
      rx_cu_data = d;
      @(negedge clk);
      rx_cu_valid = 1'b0;
      u_host.wr(a, ~d);
      rchk("rx rd", a, buf_expect(a, d));
    end
    $display("test rx done");
    u_host.wr(PAGE_SEL_ADDR, PAGE_CTRL);
    for (int k = 0; k < 3; k++)
    begin
      a = (k == 0) ? CTRL_RSVD_LO : (k == 1) ? CTRL_RSVD_FROM : CTRL_RSVD_TO;
      u_host.wr(a, 8'hFF);
      rchk("rsvd", a, ZERO_BYTE);
    end
    $display("test reserved done");
    u_host.wr(CTRL_ENABLE_ADDR, 8'h01);
    pulse(8'h02);
    chk("int masked", 8'h00, {7'h0, int_b_oe});
    pulse(8'h01);
    chk("int", 8'h01, {7'h0, int_b_oe});
    rchk("status", CTRL_STATUS_ADDR, 8'h03);
    // Undefined page code hides the status word
    u_host.wr(PAGE_SEL_ADDR, 8'h04);
    rchk("undef page", CTRL_STATUS_ADDR, ZERO_BYTE);
    rchk("undef sel", PAGE_SEL_ADDR, 8'h04);
    u_host.wr(PAGE_SEL_ADDR, PAGE_CTRL);
    u_host.wr(CTRL_STATUS_ADDR, 8'h03);
    chk("int clr", 8'h00, {7'h0, int_b_oe});
    $display("test flags done");
    u_host.wr(PAGE_SEL_ADDR, PAGE_TEST);
    rchk("locked", 7'h05, ZERO_BYTE);
    u_host.wr(TEST_KEY_ADDR, TEST_UNLOCK_CODE);
    chk("unlocked", 8'h01, {7'h0, test_mode});
    u_host.wr(TEST_KEY_ADDR, ~TEST_UNLOCK_CODE);
    chk("relocked", 8'h00, {7'h0, test_mode});
    $display("test lock done");
    tally_and_finish();
  end
endmodule
